// ---- pkg/arfp_pkg.sv ----
// Shared constants and types for the amplifier reset and fault protection block
package arfp_pkg;
   // ==================================================
   // Clock and timing
   // ==================================================
   localparam int unsigned CLK_HZ             = 25000000;
   localparam int unsigned RESET_MIN_US       = 100;
   localparam int unsigned CTRL_READY_MS      = 12;
   localparam int unsigned RESET_MIN_CYC      = (CLK_HZ / 1000000) * RESET_MIN_US;
   localparam int unsigned CTRL_READY_CYC     = (CLK_HZ / 1000) * CTRL_READY_MS;
   localparam int unsigned RETRY_UNIT_CYC     = 1024;

   // ==================================================
   // Control addresses selected by the strap
   // ==================================================
   localparam logic [6:0]  ADDR_STRAP_HIGH    = 7'h1B;
   localparam logic [6:0]  ADDR_STRAP_LOW     = 7'h1A;

   // ==================================================
   // Device register map
   // ==================================================
   localparam logic [7:0]  REG_ERROR_STATUS   = 8'h02;
   localparam logic [7:0]  REG_RETRY_DELAY    = 8'h1C;
   localparam logic [7:0]  REG_OUTPUT_MUX     = 8'h25;
   localparam logic [7:0]  ERROR_STATUS_RST   = 8'h00;
   localparam logic [7:0]  RETRY_DELAY_RST    = 8'h01;
   localparam logic [31:0] OUTPUT_MUX_RST     = 32'h0000_0000;
   localparam logic [31:0] OUTPUT_MUX_PARALLEL_BRIDGE_SELECT    = 32'h0110_3245;

   // Error status field positions
   localparam int unsigned ERR_OC_BIT         = 0;
   localparam int unsigned ERR_OT_BIT         = 1;
   localparam int unsigned ERR_UV_BIT         = 2;

   // ==================================================
   // Host Wishbone register map (word addresses as bytes)
   // ==================================================
   localparam logic [7:0]  WB_CTRL            = 8'h00;
   localparam logic [7:0]  WB_STATUS          = 8'h04;
   localparam logic [7:0]  WB_IRQ_STAT        = 8'h08;
   localparam logic [7:0]  WB_IRQ_MASK        = 8'h0C;
   localparam logic [7:0]  WB_REG_ADDR        = 8'h10;
   localparam logic [7:0]  WB_REG_WDATA       = 8'h14;
   localparam logic [7:0]  WB_REG_RDATA       = 8'h18;
   localparam int unsigned CTRL_RESET_BIT     = 0;
   localparam int unsigned CTRL_PDN_BIT       = 1;
   localparam int unsigned CTRL_GO_BIT        = 2;
   localparam int unsigned CTRL_WR_BIT        = 3;
   localparam int unsigned IRQ_FAULT_BIT      = 0;
   localparam int unsigned IRQ_DONE_BIT       = 1;
   localparam int unsigned IRQ_READY_BIT      = 2;

   // Device protection states
   typedef enum logic [1:0] {
      ARFP_RUN   = 2'b00,
      ARFP_PROT  = 2'b01,
      ARFP_RETRY = 2'b11
   } arfp_prot_t;
endpackage

// ---- pkg/arfp_if.sv ----
// Pin-level link between the host controller and the amplifier device
`timescale 1ns/100ps
interface arfp_if;
   logic        reset_n;          // Active-low device reset
   logic        power_down_n;     // Active-low power-down
   logic        reg_req;          // Register access request
   logic        reg_we;           // Write when high
   logic [7:0]  reg_addr;         // Register offset
   logic [31:0] reg_wdata;        // Write data
   logic        reg_ack;          // One-cycle access acknowledge
   logic [31:0] reg_rdata;        // Read data
   logic        reg_nak;          // Access refused
   logic        adr_fault_o;      // Device drive level of address/fault pin
   logic        adr_fault_oe;     // Device drives the pin
   logic        adr_fault_in;     // Resolved pin level (strap when undriven)
   logic        parallel_bridge_select; // Parallel bridge strap, 0 if floating
   modport device (input reset_n, power_down_n, reg_req, reg_we, reg_addr, reg_wdata,
                   input adr_fault_in, parallel_bridge_select,
                   output reg_ack, reg_rdata, reg_nak, adr_fault_o, adr_fault_oe);
   modport host (output reset_n, power_down_n, reg_req, reg_we, reg_addr, reg_wdata,
                 input reg_ack, reg_rdata, reg_nak, adr_fault_in);
endinterface

// ---- hdl/arfp_device.sv ----
// Device end: strap latch, register file, protection and retry sequencing
`timescale 1ns/100ps
// Overview of operation
// - Host holds reset low at least 100 us
// - Hold reset 100 us after supply good
// - Reset stays low 100 us past power-down
// - Strap selects address 0011011 or 0011010
// - Latch address once, then pin signals faults
// - Fault low on error, released when status cleared
// - Wait programmed retry delay, then resume
// - Retry resumes if clear, else protect again
// - Fault for overcurrent, overtemperature, undervoltage
// - Parallel mode: pair shuts down together
// - Floating parallel select means bridge-tied mode
// - Host writes mux 0x01103245 for parallel
// - Persistent overcurrent keeps outputs high impedance across retries
// - Any overcurrent shuts all four half-bridges
// - Overtemperature tristates all, auto recovers
// - Undervoltage tristates all outputs immediately
// - Power-on reset clears overload logic
module arfp_device
   import arfp_pkg::*;
#(
   parameter int unsigned READY_CYC = CTRL_READY_CYC
) (
   // Clock and power-on reset
   input  wire logic       MCLK,
   input  wire logic       SRST,
   // Link to the host
   arfp_if.device          LNK,
   // Protection detector inputs
   input  wire logic [3:0] OC_DETECT,
   input  wire logic       OT_DETECT,
   input  wire logic       UV_DETECT,
   // Half-bridge controls, play status and latched control address
   output logic [3:0]      BRIDGE_HIZ,
   output logic            PLAYING,
   output logic [6:0]      CTRL_ADDR
);
   // ==================================================
   // State
   // ==================================================
   logic [6:0]  addr_q, addr_d;               // Latched control address
   logic        strap_done_q, strap_done_d;   // Strap captured
   logic [23:0] ready_q, ready_d;             // Control-port wake-up counter
   logic [7:0]  err_q, err_d;                 // Sticky error flags
   logic [7:0]  delay_q, delay_d;             // Retry delay setting
   logic [31:0] mux_q, mux_d;                 // Output multiplexer
   logic        ack_q, ack_d;                 // Access acknowledge
   logic        nak_q, nak_d;                 // Access refused
   logic [31:0] rdata_q, rdata_d;             // Read data
   arfp_prot_t  st_q, st_d;                   // Protection state
   logic [17:0] wait_q, wait_d;               // Retry wait counter
   logic [3:0]  hiz_q, hiz_d;                 // Half-bridge high impedance
   logic        in_reset;                     // Device held in reset
   logic        port_ready;                   // Control port open
   logic        oc_any, err_now;              // Fault conditions
   logic [3:0]  oc_pair;                      // Parallel-paired overcurrent

   // Combined fault detect
   always_comb begin
      in_reset   = SRST | ~LNK.reset_n | ~LNK.power_down_n;
      port_ready = (ready_q == 24'(READY_CYC));
      oc_any     = |OC_DETECT;
      err_now    = oc_any | OT_DETECT | UV_DETECT;
      // Pulldown gives bridge-tied mode when floating
      oc_pair    = LNK.parallel_bridge_select
                   ? {{2{|OC_DETECT[3:2]}}, {2{|OC_DETECT[1:0]}}}
                   : OC_DETECT;
   end

   // ==================================================
   // Strap, wake-up and registers
   // ==================================================
   always_comb begin
      addr_d       = addr_q;
      strap_done_d = strap_done_q;
      ready_d      = ready_q;
      err_d        = err_q;
      delay_d      = delay_q;
      mux_d        = mux_q;
      ack_d        = 1'b0;
      nak_d        = 1'b0;
      rdata_d      = rdata_q;
      // Strap captured once at the first cycle out of power-on reset
      if (!strap_done_q) begin
         addr_d       = LNK.adr_fault_in ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
         strap_done_d = 1'b1;
      end
      // Wake-up counter restarts with every reset
      if (in_reset) begin
         ready_d = '0;
      end else if (!port_ready) begin
         ready_d = ready_q + 24'd1;
      end
      // One answer per request; host drops request after it
      if (LNK.reg_req && !ack_q && !nak_q) begin
         if (!port_ready) begin
            nak_d = 1'b1;
         end else begin
            ack_d = 1'b1;
            case (LNK.reg_addr)
               REG_ERROR_STATUS: begin
                  rdata_d = {24'h000000, err_q};
                  if (LNK.reg_we) begin
                     err_d = LNK.reg_wdata[7:0];
                  end
               end
               REG_RETRY_DELAY: begin
                  rdata_d = {24'h000000, delay_q};
                  if (LNK.reg_we) begin
                     delay_d = LNK.reg_wdata[7:0];
                  end
               end
               REG_OUTPUT_MUX: begin
                  rdata_d = mux_q;
                  if (LNK.reg_we) begin
                     mux_d = LNK.reg_wdata;
                  end
               end
               default: begin
                  rdata_d = 32'h0000_0000;
               end
            endcase
         end
      end
      // Sticky flags: a new event wins over the clear
      if (oc_any) begin
         err_d[ERR_OC_BIT] = 1'b1;
      end
      if (OT_DETECT) begin
         err_d[ERR_OT_BIT] = 1'b1;
      end
      if (UV_DETECT) begin
         err_d[ERR_UV_BIT] = 1'b1;
      end
   end

   // Register process for strap and registers
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         strap_done_q <= 1'b0;
         addr_q       <= ADDR_STRAP_LOW;
         ready_q      <= '0;
         err_q        <= ERROR_STATUS_RST;
         delay_q      <= RETRY_DELAY_RST;
         mux_q        <= OUTPUT_MUX_RST;
         ack_q        <= 1'b0;
         nak_q        <= 1'b0;
         rdata_q      <= '0;
      end else begin
         strap_done_q <= strap_done_d;
         addr_q       <= addr_d;
         ready_q      <= ready_d;
         err_q        <= err_d;
         delay_q      <= delay_d;
         mux_q        <= mux_d;
         ack_q        <= ack_d;
         nak_q        <= nak_d;
         rdata_q      <= rdata_d;
      end
   end

   // ==================================================
   // Protection and retry sequencing
   // ==================================================
   always_comb begin
      st_d   = st_q;
      wait_d = wait_q;
      hiz_d  = hiz_q;
      case (st_q)
         ARFP_RUN: begin
            hiz_d = oc_pair;
            if (err_now) begin
               // Any fault drops every half-bridge at once
               st_d   = ARFP_PROT;
               hiz_d  = 4'hF;
               wait_d = '0;
            end
         end
         ARFP_PROT: begin
            hiz_d = 4'hF;
            if (wait_q >= 18'({delay_q, 10'h000})) begin
               st_d = ARFP_RETRY;
            end else begin
               wait_d = wait_q + 18'd1;
            end
         end
         ARFP_RETRY: begin
            if (err_now) begin
               st_d   = ARFP_PROT;
               wait_d = '0;
            end else begin
               st_d  = ARFP_RUN;
               hiz_d = 4'h0;
            end
         end
         default: begin
            st_d  = ARFP_PROT;
            hiz_d = 4'hF;
         end
      endcase
      // Undervoltage never waits for the sequencer
      if (UV_DETECT) begin
         hiz_d = 4'hF;
      end
   end

   // Register process for protection; reset clears overload state
   always_ff @(posedge MCLK) begin
      if (SRST || in_reset) begin
         st_q   <= ARFP_RUN;
         wait_q <= '0;
         hiz_q  <= 4'hF;
      end else begin
         st_q   <= st_d;
         wait_q <= wait_d;
         hiz_q  <= hiz_d;
      end
   end

   // ==================================================
   // Outputs
   // ==================================================
   always_comb begin
      BRIDGE_HIZ       = hiz_q;
      PLAYING          = (st_q == ARFP_RUN) & ~in_reset & ~(|hiz_q);
      CTRL_ADDR        = addr_q;
      LNK.reg_ack      = ack_q;
      LNK.reg_nak      = nak_q;
      LNK.reg_rdata    = rdata_q;
      // Open-drain fault: pull low while any of the three fault flags (bits 2:0) stands
      LNK.adr_fault_o  = 1'b0;
      LNK.adr_fault_oe = strap_done_q & (|err_q[2:0]);
   end
endmodule

// ---- hdl/arfp_host.sv ----
// Host end: Wishbone slave that sequences reset and relays register accesses
`timescale 1ns/100ps
module arfp_host
   import arfp_pkg::*;
#(
   parameter int unsigned RST_CYC   = RESET_MIN_CYC,
   parameter int unsigned READY_CYC = CTRL_READY_CYC
) (
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        SRST,
   // Wishbone slave
   input  wire logic        WB_CYC,
   input  wire logic        WB_STB,
   input  wire logic        WB_WE,
   input  wire logic [7:0]  WB_ADR,
   input  wire logic [3:0]  WB_SEL,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK,
   // Interrupt
   output logic             IRQ,
   // Link to the device
   arfp_if.host             LNK
);
   logic [3:0]  ctrl_q, ctrl_d;         // Control bits
   logic [2:0]  ista_q, ista_d;         // Sticky interrupt status
   logic [2:0]  imsk_q, imsk_d;         // Interrupt mask
   logic [7:0]  radr_q, radr_d;         // Device register offset
   logic [31:0] wdat_q, wdat_d;         // Device write data
   logic [31:0] rdat_q, rdat_d;         // Last device read data
   logic        busy_q, busy_d;         // Device access in flight
   logic        rst_n_q, rst_n_d;       // Reset pin level
   logic        pdn_n_q, pdn_n_d;       // Power-down pin level
   logic [23:0] cnt_q, cnt_d;           // Reset hold then wake-up counter
   logic        rdy_q, rdy_d;           // Control port open
   logic        ack_q, ack_d;           // Bus acknowledge
   logic [31:0] dout_q, dout_d;         // Bus read data
   logic        flt_q, flt_d;           // Fault pin seen last cycle
   logic        wr;                     // Bus write strobe
   logic        go_ok;                  // Access may start

   // Sequencing and bus
   always_comb begin
      ctrl_d  = ctrl_q;
      imsk_d  = imsk_q;
      radr_d  = radr_q;
      wdat_d  = wdat_q;
      rdat_d  = rdat_q;
      busy_d  = busy_q;
      rst_n_d = rst_n_q;
      pdn_n_d = ~ctrl_q[CTRL_PDN_BIT];
      cnt_d   = cnt_q;
      rdy_d   = rdy_q;
      ack_d   = 1'b0;
      dout_d  = dout_q;
      flt_d   = LNK.adr_fault_in;
      wr      = WB_CYC & WB_STB & WB_WE & ~ack_q;
      go_ok   = rdy_q & ~busy_q;
      // Write-one clears first, so an event in the same cycle still sets its bit
      ista_d  = (wr && WB_SEL[0] && (WB_ADR == WB_IRQ_STAT)) ? (ista_q & ~WB_DAT_I[2:0]) : ista_q;
      // Reset held for the full minimum, also after power-down rises
      if (ctrl_q[CTRL_RESET_BIT] || !pdn_n_q) begin
         rst_n_d = 1'b0;
         cnt_d   = '0;
         rdy_d   = 1'b0;
      end else if (!rst_n_q) begin
         if (cnt_q >= 24'(RST_CYC - 1)) begin
            rst_n_d = 1'b1;
            cnt_d   = '0;
         end else begin
            cnt_d = cnt_q + 24'd1;
         end
      end else if (!rdy_q) begin
         if (cnt_q >= 24'(READY_CYC)) begin
            rdy_d = 1'b1;
            ista_d[IRQ_READY_BIT] = 1'b1;
         end else begin
            cnt_d = cnt_q + 24'd1;
         end
      end
      // Device access completion
      if (busy_q && (LNK.reg_ack || LNK.reg_nak)) begin
         busy_d = 1'b0;
         rdat_d = LNK.reg_nak ? 32'hFFFF_FFFF : LNK.reg_rdata;
         ista_d[IRQ_DONE_BIT] = 1'b1;
      end
      if (flt_q && !LNK.adr_fault_in && rdy_q) begin
         ista_d[IRQ_FAULT_BIT] = 1'b1;
      end
      // Bus slave, one wait state
      if (WB_CYC && WB_STB && !ack_q) begin
         ack_d = 1'b1;
         case (WB_ADR)
            WB_CTRL:      dout_d = {28'h0000000, ctrl_q};
            WB_STATUS:    dout_d = {29'h00000000, ~LNK.adr_fault_in, busy_q, rdy_q};
            WB_IRQ_STAT:  dout_d = {29'h00000000, ista_q};
            WB_IRQ_MASK:  dout_d = {29'h00000000, imsk_q};
            WB_REG_ADDR:  dout_d = {24'h000000, radr_q};
            WB_REG_WDATA: dout_d = wdat_q;
            WB_REG_RDATA: dout_d = rdat_q;
            default:      dout_d = 32'h0000_0000;
         endcase
         if (wr && WB_SEL[0]) begin
            case (WB_ADR)
               WB_CTRL: begin
                  ctrl_d = {WB_DAT_I[3], 1'b0, WB_DAT_I[1:0]};
                  if (WB_DAT_I[CTRL_GO_BIT] && go_ok) begin
                     busy_d = 1'b1;
                  end
               end
               WB_IRQ_MASK:  imsk_d = WB_DAT_I[2:0];
               WB_REG_ADDR:  radr_d = WB_DAT_I[7:0];
               default:      ;
            endcase
         end
         if (wr && (WB_ADR == WB_REG_WDATA)) begin
            wdat_d = WB_DAT_I;
         end
      end
   end

   // Register process
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl_q  <= 4'h1;
         ista_q  <= '0;
         imsk_q  <= '0;
         radr_q  <= '0;
         wdat_q  <= '0;
         rdat_q  <= '0;
         busy_q  <= 1'b0;
         rst_n_q <= 1'b0;
         pdn_n_q <= 1'b1;
         cnt_q   <= '0;
         rdy_q   <= 1'b0;
         ack_q   <= 1'b0;
         dout_q  <= '0;
         flt_q   <= 1'b1;
      end else begin
         ctrl_q  <= ctrl_d;
         ista_q  <= ista_d;
         imsk_q  <= imsk_d;
         radr_q  <= radr_d;
         wdat_q  <= wdat_d;
         rdat_q  <= rdat_d;
         busy_q  <= busy_d;
         rst_n_q <= rst_n_d;
         pdn_n_q <= pdn_n_d;
         cnt_q   <= cnt_d;
         rdy_q   <= rdy_d;
         ack_q   <= ack_d;
         dout_q  <= dout_d;
         flt_q   <= flt_d;
      end
   end

   // Outputs
   always_comb begin
      WB_ACK           = ack_q;
      WB_DAT_O         = dout_q;
      IRQ              = |(ista_q & imsk_q);
      LNK.reset_n      = rst_n_q;
      LNK.power_down_n = pdn_n_q;
      LNK.reg_req      = busy_q;
      LNK.reg_we       = ctrl_q[CTRL_WR_BIT];
      LNK.reg_addr     = radr_q;
      LNK.reg_wdata    = wdat_q;
   end
endmodule

// ---- verif/arfp_link_properties.sv ----
// Concurrent checks on the link between host and device ends
`timescale 1ns/100ps
module arfp_link_check
   import arfp_pkg::*;
#(
   parameter int unsigned RST_CYC   = RESET_MIN_CYC,
   parameter int unsigned READY_CYC = CTRL_READY_CYC
) (
   // Clock and reset
   input wire logic       MCLK,
   input wire logic       SRST,
   // Link signals
   input wire logic       reset_n,
   input wire logic       power_down_n,
   input wire logic       reg_req,
   input wire logic       reg_we,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_ack,
   input wire logic       reg_nak,
   input wire logic       adr_fault_oe
);
   int unsigned low_q;  // Cycles reset held low with power-down released
   int unsigned run_q;  // Cycles since reset released
   int unsigned rdy_q;  // Cycles with reset and power-down both released
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   // ==========================================
   // Helper counters
   // ==========================================
   // Counters restart whenever their condition drops
   always_ff @(posedge MCLK) begin
      low_q <= (SRST || reset_n || !power_down_n) ? 0 : low_q + 1;
      run_q <= (SRST || !reset_n) ? 0 : run_q + 1;
      rdy_q <= (SRST || !reset_n || !power_down_n) ? 0 : rdy_q + 1;
   end
   // ==========================================
   // Assertions
   // ==========================================
   a_reset_long_enough: assert property ($rose(reset_n) |-> low_q >= RST_CYC - 1)
      else $error("reset released too early");
   a_req_after_ready: assert property ($rose(reg_req) |-> run_q >= READY_CYC - 1)
      else $error("request before port ready");
   a_ack_when_ready: assert property (reg_ack |-> rdy_q >= READY_CYC - 1)
      else $error("access accepted before port ready");
   a_answer_next_cycle: assert property (reg_req && !reg_ack && !reg_nak |=> reg_ack || reg_nak)
      else $error("link request not answered next cycle");
   a_answer_single: assert property (reg_ack || reg_nak |=> !reg_ack && !reg_nak)
      else $error("link answer longer than one cycle");
   a_ack_nak_excl: assert property (!(reg_ack && reg_nak))
      else $error("ack and nak together");
   a_strap_pin_free: assert property ($fell(SRST) |-> !adr_fault_oe)
      else $error("pin driven while strap is sampled");
   a_fault_pin_sticky: assert property (adr_fault_oe && reset_n
      && !(reg_req && reg_we && reg_addr == REG_ERROR_STATUS) |=> adr_fault_oe)
      else $error("fault pin released without status clear");
   // Main scenarios
   c_read_done: cover property (reg_ack && !reg_we);
   c_pin_release: cover property ($fell(adr_fault_oe));
   c_reset_release: cover property ($rose(reset_n));
endmodule

// ---- verif/tb_amp_reset_fault_protection.sv ----
// Self-checking bench joining the host and device ends
`timescale 1ns/100ps
module tb_amp_reset_fault_protection;
   import arfp_pkg::*;
   localparam int unsigned RST = 10;     // Shortened reset hold
   localparam int unsigned RDY = 50;     // Shortened port ready delay
   logic        mclk = 1'b0;             // System clock
   logic        srst = 1'b1;             // Synchronous reset
   logic        cyc = 1'b0;              // Wishbone cycle
   logic        stb = 1'b0;              // Wishbone strobe
   logic        we = 1'b0;               // Wishbone write
   logic [7:0]  adr = 8'h00;             // Wishbone address
   logic [31:0] wdat = 32'h0;            // Wishbone write data
   logic        strap = 1'b0;            // External resistor on the pin
   logic        pbs = 1'b0;              // Parallel bridge select
   logic [3:0]  oc = 4'h0;               // Overcurrent detectors
   logic        ot = 1'b0;               // Overtemperature detector
   logic        uv = 1'b0;               // Undervoltage detector
   logic [31:0] rdat, rd, d, r;          // Bus data, last read, delay, random
   logic        ack, irq, play;          // Design outputs
   logic [3:0]  hiz;                     // Half-bridge high impedance
   logic [6:0]  caddr;                   // Latched control address
   logic [7:0]  ra [3] = '{REG_ERROR_STATUS, REG_RETRY_DELAY, REG_OUTPUT_MUX};
   logic [31:0] rv [3] = '{32'(ERROR_STATUS_RST), 32'(RETRY_DELAY_RST), OUTPUT_MUX_RST};
   int          error_cnt = 0;           // Mismatches
   int          n_compared = 0;          // Comparisons made
   int          seed = 49;               // Fixed random seed
   // Pin is pulled low by the device, else shows the strap resistor
   arfp_if lnk ();
   assign lnk.adr_fault_in = lnk.adr_fault_oe ? lnk.adr_fault_o : strap;
   assign lnk.parallel_bridge_select = pbs;
   arfp_host #(.RST_CYC(RST), .READY_CYC(RDY)) i_arfp_host (.MCLK(mclk), .SRST(srst), .WB_CYC(cyc),
      .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK(ack), .IRQ(irq), .LNK(lnk));
   arfp_device #(.READY_CYC(RDY)) i_arfp_device (.MCLK(mclk), .SRST(srst), .LNK(lnk), .OC_DETECT(oc),
      .OT_DETECT(ot), .UV_DETECT(uv), .BRIDGE_HIZ(hiz), .PLAYING(play), .CTRL_ADDR(caddr));
   arfp_link_check #(.RST_CYC(RST), .READY_CYC(RDY)) i_arfp_link_check (.MCLK(mclk), .SRST(srst),
      .reset_n(lnk.reset_n), .power_down_n(lnk.power_down_n), .reg_req(lnk.reg_req), .reg_we(lnk.reg_we),
      .reg_addr(lnk.reg_addr), .reg_ack(lnk.reg_ack), .reg_nak(lnk.reg_nak), .adr_fault_oe(lnk.adr_fault_oe));
   // ==========================================
   // Clock and helpers
   // ==========================================
   initial begin
      forever #20 mclk = ~mclk;
   end
   // Compare one value and count it
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Classic Wishbone single cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
      int k;
      k = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= dt;
      do begin
         @(posedge mclk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) error_cnt++;
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Relay one device register access and fetch its read data
   task automatic dev(input logic w, input logic [7:0] a, input logic [31:0] dt);
      int n;
      n = 0;
      wb(1'b1, WB_REG_ADDR, 32'(a));
      wb(1'b1, WB_REG_WDATA, dt);
      wb(1'b1, WB_CTRL, w ? 32'h0000_000C : 32'h0000_0004);
      do begin
         wb(1'b0, WB_STATUS, 32'h0);
         n++;
      end while (rd[1] !== 1'b0 && n < 20);
      wb(1'b0, WB_REG_RDATA, 32'h0);
   endtask
   // Error flag expected for each protection cause
   function automatic logic [31:0] exp_err(input int c);
      if (c == 4) return 32'h1 << ERR_OT_BIT;
      if (c == 5) return 32'h1 << ERR_UV_BIT;
      return 32'h1 << ERR_OC_BIT;
   endfunction
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      complete_run();
   end
   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      // Both strap levels, then strap moved after the latch
      for (int s = 0; s < 2; s++) begin
         @(posedge mclk);
         strap <= s[0];
         srst <= 1'b1;
         repeat (10) @(posedge mclk);
         srst <= 1'b0;
         repeat (3) @(posedge mclk);
         strap <= ~s[0];
         repeat (2) @(posedge mclk);
         chk("ctrl_addr", 32'(s ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW), 32'(caddr));
      end
      strap <= 1'b1;
      wb(1'b0, WB_CTRL, 32'h0);
      chk("ctrl", 32'h1, rd);
      // Reset released while power-down is held, then power-down released
      wb(1'b1, WB_IRQ_MASK, 32'h4);
      wb(1'b1, WB_CTRL, 32'h2);
      repeat (RST * 3) @(posedge mclk);
      chk("reset_n", 32'h0, 32'(lnk.reset_n));
      wb(1'b1, WB_CTRL, 32'h0);
      for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge mclk);
      wb(1'b0, WB_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h4, rd);
      wb(1'b1, WB_IRQ_STAT, 32'h4);
      wb(1'b0, WB_STATUS, 32'h0);
      chk("ready", 32'h1, 32'(rd[0]));
      // Device register reset values, mux write, unmapped host address
      for (int i = 0; i < 3; i++) begin
         dev(1'b0, ra[i], 32'h0);
         chk("reg_reset", rv[i], rd);
      end
      dev(1'b1, REG_OUTPUT_MUX, OUTPUT_MUX_PARALLEL_BRIDGE_SELECT);
      dev(1'b0, REG_OUTPUT_MUX, 32'h0);
      chk("output_mux", OUTPUT_MUX_PARALLEL_BRIDGE_SELECT, rd);
      wb(1'b1, 8'hFC, 32'h5A5A_5A5A);
      wb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(1'b1, WB_IRQ_MASK, 32'h1);
      wb(1'b1, WB_IRQ_STAT, 32'h7);
      // Each protection cause, the last one persistent over a retry
      for (int c = 0; c < 7; c++) begin
         r = $random(seed);
         d = 32'h1 + (r & 32'h1);
         dev(1'b1, REG_RETRY_DELAY, d);
         @(posedge mclk);
         pbs <= r[4];
         oc <= (c < 4 || c == 6) ? 4'h1 << (r[3:2] | c[1:0]) : 4'h0;
         ot <= (c == 4);
         uv <= (c == 5);
         repeat (3) @(posedge mclk);
         chk("hiz", 32'hF, 32'(hiz));
         chk("pin", 32'h0, 32'(lnk.adr_fault_in));
         chk("irq", 32'h1, 32'(irq));
         if (c != 6) oc <= 4'h0;
         ot <= 1'b0;
         uv <= 1'b0;
         repeat (d * 1024 - 20) @(posedge mclk);
         chk("hiz_wait", 32'hF, 32'(hiz));
         repeat (40) @(posedge mclk);
         chk("hiz_retry", c == 6 ? 32'hF : 32'h0, 32'(hiz));
         oc <= 4'h0;
         repeat (d * 1024 + 40) @(posedge mclk);
         chk("playing", 32'h1, 32'(play));
         chk("pin_held", 32'h0, 32'(lnk.adr_fault_in));
         dev(1'b0, REG_ERROR_STATUS, 32'h0);
         chk("error_status", exp_err(c), rd);
         dev(1'b1, REG_ERROR_STATUS, 32'h0);
         chk("pin_free", 32'h1, 32'(lnk.adr_fault_in));
         wb(1'b1, WB_IRQ_MASK, 32'h0);
         chk("irq_masked", 32'h0, 32'(irq));
         wb(1'b1, WB_IRQ_MASK, 32'h1);
         wb(1'b1, WB_IRQ_STAT, 32'h7);
         repeat (2) @(posedge mclk);
         chk("irq_clear", 32'h0, 32'(irq));
      end
      complete_run();
   end
endmodule
